// ===== verilog/adc_lp_pkg.sv
// Constants for the low-power converter control block
package adc_lp_pkg;
  localparam logic [2:0] ADDR_CFG = 3'h0;
  localparam logic [2:0] ADDR_SC2 = 3'h1;
  localparam logic [2:0] ADDR_SC1 = 3'h2;
  localparam logic [2:0] ADDR_RH = 3'h3;
  localparam logic [2:0] ADDR_RL = 3'h4;
  localparam logic [2:0] ADDR_CVH = 3'h5;
  localparam logic [2:0] ADDR_CVL = 3'h6;
  localparam logic [2:0] ADDR_PIN = 3'h7;
  localparam int CFG_LP = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CFE = 5;
  localparam int SC2_CGT = 4;
  localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CO = 5;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [7:0] SC1_RESET = 8'h1F;
  // Sample windows in half clocks: 3.5 and 23.5 cycles
  localparam logic [5:0] SAMPLE_SHORT_HALVES = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALVES = 6'h2F;
endpackage : adc_lp_pkg

// ===== verilog/adc_lp_tick.sv
// Conversion clock tick generator with divider
`timescale 1ns/100ps
module adc_lp_tick
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_async_tick,
  input wire logic [1:0] i_source,
  input wire logic [1:0] i_div,
  output logic o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } state_type;
  state_type st, next_st;
  logic src;
  always_comb
  begin
    next_st = st;
    src = (i_source == adc_lp_pkg::CLK_ASYNC) ? i_async_tick : 1'b1;
    next_st.tick = 1'b0;
    if (src)
    begin
      if (st.cnt >= ((8'h01 << i_div) - 8'h01))
      begin
        next_st.cnt = 8'h00;
        next_st.tick = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 8'h01;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else
      st <= next_st;
  end
  assign o_tick = st.tick;
endmodule : adc_lp_tick

// ===== verilog/adc_lowpower_control.sv
// Converter control: registers, sequencing, stop-mode handling
`timescale 1ns/100ps
module adc_lowpower_control
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_light_stop,
  input wire logic i_deep_stop,
  input wire logic i_hw_trigger,
  input wire logic i_async_tick,
  input wire logic [9:0] i_sample_code,
  input wire logic i_above_high_ref,
  input wire logic i_below_low_ref,
  output logic o_irq,
  output logic o_converter_on,
  output logic [4:0] o_channel,
  output logic [7:0] o_pin_digital_disable
);
  typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT} phase_type;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] sc2;
    logic [7:0] sc1;
    logic [9:0] result;
    logic [9:0] cmpv;
    logic [7:0] pin;
    logic [7:0] rdata;
    logic high_read;
    logic stopped;
    phase_type phase;
    logic [5:0] cnt;
    logic [9:0] sample;
    logic irq;
    logic busy;
    logic [2:0] trg_sync;
    logic trg_level;
  } state_type;
  state_type st, next_st;
  logic tick;
  logic trg_rise;
  logic is10;
  logic [9:0] code;
  logic [10:0] diff;
  logic cond;
  logic start_req;
  adc_lp_tick u_tick
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async_tick(i_async_tick),
    .i_source(st.cfg[adc_lp_pkg::CFG_CLK_LSB +: 2]),
    .i_div(st.cfg[adc_lp_pkg::CFG_DIV_LSB +: 2]),
    .o_tick(tick)
  );
  assign is10 = st.cfg[adc_lp_pkg::CFG_MODE_LSB +: 2] == adc_lp_pkg::MODE_10;
  assign trg_rise = (st.trg_sync[2] == st.trg_sync[1]) && st.trg_sync[1]
    && !st.trg_level;
  always_comb
  begin
    next_st = st;
    code = 10'h000;
    diff = 11'h000;
    cond = 1'b0;
    start_req = 1'b0;
    next_st.trg_sync = {st.trg_sync[1:0], i_hw_trigger};
    if (st.trg_sync[2] == st.trg_sync[1])
      next_st.trg_level = st.trg_sync[1];
    next_st.rdata = 8'h00;
    if (i_rd && i_addr == adc_lp_pkg::ADDR_RH)
      next_st.high_read = is10;
    if (i_rd && i_addr == adc_lp_pkg::ADDR_RL)
      next_st.high_read = 1'b0;
    if (i_rd)
    begin
      unique case (i_addr)
        adc_lp_pkg::ADDR_CFG: next_st.rdata = st.cfg;
        adc_lp_pkg::ADDR_SC2:
          next_st.rdata = {st.phase != IDLE, st.sc2[6:4], 4'h0};
        adc_lp_pkg::ADDR_SC1: next_st.rdata = st.sc1;
        adc_lp_pkg::ADDR_RH: next_st.rdata = {6'h00, st.result[9:8]};
        adc_lp_pkg::ADDR_RL: next_st.rdata = st.result[7:0];
        adc_lp_pkg::ADDR_CVH: next_st.rdata = {6'h00, st.cmpv[9:8]};
        adc_lp_pkg::ADDR_CVL: next_st.rdata = st.cmpv[7:0];
        adc_lp_pkg::ADDR_PIN: next_st.rdata = st.pin;
      endcase
    end
    // Software start: any write except to RH/RL aborts; an sc1 write restarts unless trigger mode, channel off or light stop
    if (i_wr)
    begin
      next_st.phase = IDLE;
      unique case (i_addr)
        adc_lp_pkg::ADDR_CFG: next_st.cfg = i_wdata;
        adc_lp_pkg::ADDR_SC2: next_st.sc2 = {1'b0, i_wdata[6:4], 4'h0};
        adc_lp_pkg::ADDR_SC1:
        begin
          next_st.sc1 = {1'b0, i_wdata[6:0]};
          start_req = !st.sc2[adc_lp_pkg::SC2_TRG]
            && i_wdata[4:0] != adc_lp_pkg::CH_OFF && !i_light_stop;
        end
        adc_lp_pkg::ADDR_CVH: next_st.cmpv[9:8] = i_wdata[1:0];
        adc_lp_pkg::ADDR_CVL: next_st.cmpv[7:0] = i_wdata;
        adc_lp_pkg::ADDR_PIN: next_st.pin = i_wdata;
        default: next_st.phase = st.phase;
      endcase
      if (i_addr == adc_lp_pkg::ADDR_RH || i_addr == adc_lp_pkg::ADDR_RL)
        next_st.phase = st.phase;
    end
    // Reading the status register clears nothing; a sc1 write clears flag
    // hardware trigger starts also in light stop, only with the async clock selected
    if (st.sc2[adc_lp_pkg::SC2_TRG] && trg_rise
      && st.sc1[4:0] != adc_lp_pkg::CH_OFF)
      start_req = 1'b1;
    if (i_light_stop && st.cfg[1:0] != adc_lp_pkg::CLK_ASYNC)
    begin
      next_st.phase = IDLE;
      next_st.stopped = 1'b1;
      start_req = 1'b0;
    end
    // idle until new trigger
    // Stopped marker lasts past the exit, until a real start clears it
    if (start_req && next_st.phase == IDLE)
    begin
      next_st.phase = SAMPLE;
      next_st.stopped = 1'b0;
      next_st.cnt = st.cfg[adc_lp_pkg::CFG_LSMP] ?
        adc_lp_pkg::SAMPLE_LONG_HALVES : adc_lp_pkg::SAMPLE_SHORT_HALVES;
    end
    // async clock keeps running in light stop
    // Advance only what no abort has cancelled in this same cycle
    else if (tick && next_st.phase == SAMPLE)
    begin
      if (st.cnt <= 6'h02)
      begin
        next_st.phase = CONVERT;
        next_st.cnt = is10 ? 6'h0A : 6'h08;
        next_st.sample = i_sample_code;
      end
      else
        next_st.cnt = st.cnt - 6'h02;
    end
    else if (tick && next_st.phase == CONVERT)
    begin
      if (st.cnt > 6'h01)
        next_st.cnt = st.cnt - 6'h01;
      else
      begin
        if (i_above_high_ref)
          code = is10 ? 10'h3FF : 10'h0FF;
        else if (i_below_low_ref)
          code = 10'h000;
        else
          code = is10 ? st.sample : {2'h0, st.sample[9:2]};
        diff = {1'b0, code} - {1'b0, st.cmpv};
        cond = !st.sc2[adc_lp_pkg::SC2_CFE]
          || (st.sc2[adc_lp_pkg::SC2_CGT] ? !diff[10] : diff[10]);
        next_st.phase = IDLE;
        if (cond && st.high_read)
        begin
          next_st.phase = SAMPLE;
          next_st.cnt = st.cfg[adc_lp_pkg::CFG_LSMP] ?
            adc_lp_pkg::SAMPLE_LONG_HALVES : adc_lp_pkg::SAMPLE_SHORT_HALVES;
        end
        else
        begin
          if (cond)
          begin
            next_st.sc1[adc_lp_pkg::SC1_CONVERSION_COMPLETE_FLAG] = 1'b1;
            next_st.result = st.sc2[adc_lp_pkg::SC2_CFE] ? diff[9:0] : code;
          end
          if (st.sc1[adc_lp_pkg::SC1_CO])
          begin
            next_st.phase = SAMPLE;
            next_st.cnt = st.cfg[adc_lp_pkg::CFG_LSMP] ?
              adc_lp_pkg::SAMPLE_LONG_HALVES :
              adc_lp_pkg::SAMPLE_SHORT_HALVES;
          end
        end
      end
    end
    next_st.irq = next_st.sc1[adc_lp_pkg::SC1_CONVERSION_COMPLETE_FLAG]
      && next_st.sc1[adc_lp_pkg::SC1_IEN];
    next_st.busy = next_st.phase != IDLE;
  end
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st <= '0;
      st.sc1 <= adc_lp_pkg::SC1_RESET;
      st.phase <= IDLE;
    end
    // deep stop returns all control registers to reset values; the tick divider keeps its count
    else if (i_deep_stop)
    begin
      st <= '0;
      st.sc1 <= adc_lp_pkg::SC1_RESET;
      st.phase <= IDLE;
    end
    else
      st <= next_st;
  end
  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_converter_on = st.busy;
  assign o_channel = st.sc1[4:0];
  assign o_pin_digital_disable = st.pin;
  property p_abort;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_light_stop && st.cfg[1:0] != adc_lp_pkg::CLK_ASYNC && !i_deep_stop)
      |=> st.phase == IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort in stop");
  property p_result_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    ($rose(i_light_stop) && st.cfg[1:0] != adc_lp_pkg::CLK_ASYNC
      && !i_deep_stop) |=> $stable(st.result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed on stop");
  property p_irq;
    @(posedge i_clk) disable iff (!i_rstn)
    o_irq |-> st.sc1[adc_lp_pkg::SC1_CONVERSION_COMPLETE_FLAG] && st.sc1[adc_lp_pkg::SC1_IEN];
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_deep;
    @(posedge i_clk) disable iff (!i_rstn)
    i_deep_stop |=> st.cfg == 8'h00 && st.phase == IDLE;
  endproperty
  a_deep: assert property (p_deep) else $error("deep stop kept state");
  property p_sc2_zero;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == adc_lp_pkg::ADDR_SC2) |=> o_rdata[3:0] == 4'h0;
  endproperty
  a_sc2_zero: assert property (p_sc2_zero)
    else $error("sc2 low bits nonzero");
  property p_block;
    @(posedge i_clk) disable iff (!i_rstn)
    (st.high_read && !i_rd && !i_wr && !i_deep_stop) |=> $stable(st.result);
  endproperty
  a_block: assert property (p_block) else $error("blocked result moved");
  property p_stay_idle;
    @(posedge i_clk) disable iff (!i_rstn)
    (st.stopped && st.phase == IDLE && !trg_rise && !i_wr)
      |=> st.phase == IDLE;
  endproperty
  a_stay_idle: assert property (p_stay_idle)
    else $error("started without trigger");
  property p_ls_start;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_light_stop && st.phase == IDLE && !trg_rise && !i_deep_stop)
      |=> st.phase == IDLE;
  endproperty
  a_ls_start: assert property (p_ls_start)
    else $error("software start in stop");
endmodule : adc_lowpower_control

// ===== tb/testbench.sv
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_light_stop = 1'b0;
  logic i_deep_stop = 1'b0;
  logic i_hw_trigger = 1'b0;
  logic i_async_tick = 1'b0;
  logic [9:0] i_sample_code = 10'h2A5;
  logic i_above_high_ref = 1'b0;
  logic i_below_low_ref = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_converter_on;
  logic [4:0] o_channel;
  logic [7:0] o_pin_digital_disable;
  logic [1:0] tick_cnt = 2'h0;
  logic got;
  int n_fail = 0;
  int checks = 0;

  always #10 i_clk = ~i_clk;

  // Async clock enable runs free, one pulse every four bus cycles
  always @(posedge i_clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    i_async_tick <= (tick_cnt == 2'h0);
  end

  adc_lowpower_control adc_lowpower_control_inst
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_light_stop(i_light_stop),
    .i_deep_stop(i_deep_stop),
    .i_hw_trigger(i_hw_trigger),
    .i_async_tick(i_async_tick),
    .i_sample_code(i_sample_code),
    .i_above_high_ref(i_above_high_ref),
    .i_below_low_ref(i_below_low_ref),
    .o_irq(o_irq),
    .o_converter_on(o_converter_on),
    .o_channel(o_channel),
    .o_pin_digital_disable(o_pin_digital_disable)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Trailing delay lets registered outputs settle before a compare
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rdchk

  // Always waits the full span so that a late completion is also seen
  task automatic wait_irq(input int n);
    got = 1'b0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      if (o_irq === 1'b1)
        got = 1'b1;
    end
  endtask : wait_irq

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdchk(adc_lp_pkg::ADDR_CFG, 8'h00);
    rdchk(adc_lp_pkg::ADDR_SC2, 8'h00);
    rdchk(adc_lp_pkg::ADDR_SC1, adc_lp_pkg::SC1_RESET);
    wr(adc_lp_pkg::ADDR_CFG, 8'h98);
    rdchk(adc_lp_pkg::ADDR_CFG, 8'h98);
    wr(adc_lp_pkg::ADDR_SC2, 8'h3C);
    rdchk(adc_lp_pkg::ADDR_SC2, 8'h30);
    wr(adc_lp_pkg::ADDR_SC2, 8'h00);
    wr(adc_lp_pkg::ADDR_PIN, 8'h02);
    chk(o_pin_digital_disable, 16'h0002);
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    chk(o_channel, 16'h0001);
    wait_irq(200);
    chk(got, 16'h0001);
    rdchk(adc_lp_pkg::ADDR_SC1, 8'hC1);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h02);
    rdchk(adc_lp_pkg::ADDR_RL, 8'hA5);
    // Full scale and zero clamps at 10 bits
    for (int k = 0; k < 2; k++)
    begin
      i_above_high_ref <= (k == 0);
      i_below_low_ref <= (k == 1);
      wr(adc_lp_pkg::ADDR_SC1, 8'h41);
      wait_irq(200);
      rdchk(adc_lp_pkg::ADDR_RH, (k == 0) ? 8'h03 : 8'h00);
      rdchk(adc_lp_pkg::ADDR_RL, (k == 0) ? 8'hFF : 8'h00);
    end
    i_below_low_ref <= 1'b0;
    // Light stop on the bus clock aborts, results stay
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_converter_on, 16'h0001);
    rdchk(adc_lp_pkg::ADDR_SC2, 8'h80);
    i_light_stop <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    chk(o_converter_on, 16'h0000);
    i_light_stop <= 1'b0;
    wait_irq(200);
    chk(got, 16'h0000);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h00);
    rdchk(adc_lp_pkg::ADDR_RL, 8'h00);
    // Async clock keeps converting through light stop, 8-bit scale
    wr(adc_lp_pkg::ADDR_CFG, 8'h03);
    i_above_high_ref <= 1'b1;
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    i_light_stop <= 1'b1;
    wait_irq(400);
    chk(got, 16'h0001);
    i_light_stop <= 1'b0;
    rdchk(adc_lp_pkg::ADDR_RL, 8'hFF);
    // Hardware trigger starts a conversion during light stop
    i_above_high_ref <= 1'b0;
    wr(adc_lp_pkg::ADDR_SC2, 8'h40);
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    i_light_stop <= 1'b1;
    wait_irq(150);
    chk(got, 16'h0000);
    i_hw_trigger <= 1'b1;
    wait_irq(400);
    chk(got, 16'h0001);
    i_hw_trigger <= 1'b0;
    i_light_stop <= 1'b0;
    // Compare against 0x200, both senses
    wr(adc_lp_pkg::ADDR_CFG, 8'h08);
    wr(adc_lp_pkg::ADDR_CVH, 8'h02);
    wr(adc_lp_pkg::ADDR_CVL, 8'h00);
    wr(adc_lp_pkg::ADDR_SC2, 8'h30);
    i_sample_code <= 10'h100;
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    wait_irq(200);
    chk(got, 16'h0000);
    i_sample_code <= 10'h300;
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    wait_irq(200);
    chk(got, 16'h0001);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h01);
    rdchk(adc_lp_pkg::ADDR_RL, 8'h00);
    wr(adc_lp_pkg::ADDR_SC2, 8'h20);
    i_sample_code <= 10'h100;
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    wait_irq(200);
    chk(got, 16'h0001);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h03);
    rdchk(adc_lp_pkg::ADDR_RL, 8'h00);
    // Half-read result blocks continuous updates until low byte read
    wr(adc_lp_pkg::ADDR_SC2, 8'h00);
    i_sample_code <= 10'h2A5;
    wr(adc_lp_pkg::ADDR_SC1, 8'h61);
    wait_irq(100);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h02);
    i_sample_code <= 10'h155;
    wait_irq(200);
    rdchk(adc_lp_pkg::ADDR_RL, 8'hA5);
    wait_irq(100);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h01);
    rdchk(adc_lp_pkg::ADDR_RL, 8'h55);
    // Deep stop returns cfg, sc2, sc1 and the result to reset and leaves the converter idle with no interrupt
    i_deep_stop <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_deep_stop <= 1'b0;
    rdchk(adc_lp_pkg::ADDR_CFG, 8'h00);
    rdchk(adc_lp_pkg::ADDR_SC2, 8'h00);
    rdchk(adc_lp_pkg::ADDR_SC1, adc_lp_pkg::SC1_RESET);
    rdchk(adc_lp_pkg::ADDR_RH, 8'h00);
    chk(o_converter_on, 16'h0000);
    chk(o_irq, 16'h0000);
    // Full reconfiguration after deep stop; long window cannot end in 20
    wr(adc_lp_pkg::ADDR_CFG, 8'h18);
    wr(adc_lp_pkg::ADDR_SC2, 8'h00);
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    wait_irq(20);
    chk(got, 16'h0000);
    wait_irq(100);
    chk(got, 16'h0001);
    wr(adc_lp_pkg::ADDR_CFG, 8'h08);
    wr(adc_lp_pkg::ADDR_SC1, 8'h41);
    wait_irq(20);
    chk(got, 16'h0001);
    stop_test();
  end
endmodule : testbench
